// ### dv/athc_bus_master.sv
// Two-wire bus master model for the converter bench.
// Assumes the bench resolves open-drain wires with pull-ups.
`timescale 1ns/1ps
module athc_bus_master #(
	parameter int QCYC = 30
) (
	// Clock
	input wire logic clk_i,
	// Resolved bus levels
	input wire logic scl_i,
	input wire logic sda_i,
	// Releases, high = line let go
	output logic scl_rel_o,
	output logic sda_rel_o
);
	// ==========================================================
	// Idle and timing
	initial begin
		scl_rel_o = 1'b1;
		sda_rel_o = 1'b1;
	end

	// Quarter bit, 600 ns bit time
	task automatic step();
		repeat (QCYC) @(posedge clk_i);
		#1;
	endtask

	// Let clock go, wait out stretching
	// A clock held low forever is caught by the bench watchdog
	task automatic rise_scl();
		scl_rel_o = 1'b1;
		while (scl_i !== 1'b1) begin
			@(posedge clk_i);
		end
		#1;
	endtask

	// ==========================================================
	// Framing
	task automatic bus_start();
		sda_rel_o = 1'b1;
		step();
		rise_scl();
		step();
		sda_rel_o = 1'b0;
		step();
		scl_rel_o = 1'b0;
		step();
	endtask

	task automatic bus_stop();
		sda_rel_o = 1'b0;
		step();
		rise_scl();
		step();
		sda_rel_o = 1'b1;
		step();
		step();
	endtask

	// Data changes only while clock is low
	task automatic bus_bit(input logic b, output logic r);
		sda_rel_o = b;
		step();
		rise_scl();
		step();
		r = sda_i;
		step();
		scl_rel_o = 1'b0;
		step();
	endtask

	task automatic bus_byte(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bus_bit(d[i], q[i]);
		end
		bus_bit(ack_in, ack_out);
	endtask
endmodule // athc_bus_master

// ### dv/testbench.sv
// Self-checking bench for the converter control block.
// Assumes the bus master model and default design parameters.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module testbench import athc_pkg::*; ;
	// ==========================================================
	// Signals
	localparam logic [6:0] ADDR = DEV_ADDR_RST;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [RES_W-1:0] analog_input_zero = '0;
	logic [RES_W-1:0] analog_input_one = '0;
	logic scl_o, scl_oe, sda_o, sda_oe, scl_rel, sda_rel, scl_w, sda_w;
	logic track, busy, rvalid;
	logic [RES_W-1:0] result;
	athc_cfg_type cfg;
	int seed, check_count, n_mismatch;

	always #2.5 clk_sys_i = ~clk_sys_i;
	assign scl_w = scl_rel & (scl_oe ? scl_o : 1'b1);
	assign sda_w = sda_rel & (sda_oe ? sda_o : 1'b1);

	athc_top dut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.analog_input_zero_i(analog_input_zero), .analog_input_one_i(analog_input_one),
		.cfg_o(cfg), .track_o(track), .busy_o(busy),
		.result_valid_o(rvalid), .result_o(result)
	);

	athc_bus_master mst (
		.clk_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w),
		.scl_rel_o(scl_rel), .sda_rel_o(sda_rel)
	);

	// ==========================================================
	// Reference model
	function automatic logic [9:0] exp_code(input int a0, input int a1,
		input logic bip, input logic sgl, input logic cs);
		int pos, neg, d;
		pos = cs ? a1 : a0;
		neg = cs ? a0 : a1;
		d = pos - neg;
		if (sgl)
			return 10'(pos);
		if (bip)
			return 10'(d >>> 1);
		return (d < 0) ? 10'h000 : 10'(d);
	endfunction

	// ==========================================================
	// Tasks
	task automatic send(input logic [7:0] d, input logic exp_ack);
		logic [7:0] q;
		logic a;
		mst.bus_byte(d, 1'b1, q, a);
		`CHK(a, exp_ack)
	endtask

	task automatic rd_conv(input logic ext, output logic [9:0] got);
		logic [7:0] b0, b1;
		logic a;
		mst.bus_start();
		for (int i = 6; i >= 0; i--) begin
			mst.bus_bit(ADDR[i], a);
		end
		mst.bus_bit(1'b1, a);
		`CHK(track, 1'b1)
		mst.bus_bit(1'b1, a);
		`CHK(a, 1'b0)
		`CHK(track, ext)
		`CHK(scl_oe, ~ext)
		`CHK(busy, ~ext)
		mst.bus_byte(8'hFF, 1'b0, b0, a);
		mst.bus_byte(8'hFF, 1'b1, b1, a);
		`CHK(track, 1'b0)
		mst.bus_stop();
		`CHK(b0[7:2], 6'h3F)
		got = {b0[1:0], b1};
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		#400us;
		n_mismatch++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		logic ext, bip, sgl, cs;
		logic [9:0] got, exp;
		seed = 14679;
		repeat (3) @(posedge clk_sys_i);
		#1 resetn_i = 1'b1;
		`CHK(cfg, 4'b0010)
		repeat (3) @(posedge clk_sys_i);
		#1;
		mst.bus_start();
		send({ADDR ^ 7'h01, 1'b0}, 1'b1);
		mst.bus_stop();
		`CHK({scl_oe, sda_oe}, 2'b00)
		$display("test wrong_address done");
		for (int m = 0; m < 8; m++) begin
			{ext, bip, sgl} = m[2:0];
			cs = 1'($random(seed));
			@(posedge clk_sys_i);
			#1;
			analog_input_zero = 10'($random(seed));
			analog_input_one = 10'($random(seed));
			mst.bus_start();
			send({ADDR, 1'b0}, 1'b0);
			send({4'h8, ext, bip, 2'h2}, 1'b0);
			send({6'h00, cs, sgl}, 1'b0);
			mst.bus_stop();
			`CHK(cfg, {ext, bip, sgl, cs})
			rd_conv(ext, got);
			exp = exp_code(analog_input_zero, analog_input_one, bip, sgl, cs);
			`CHK(got, exp)
			`CHK(result, exp)
			`CHK(rvalid, 1'b1)
			`CHK(busy, 1'b0)
			$display("test mode %0d done", m);
		end
		mst.bus_start();
		send({ADDR, 1'b0}, 1'b0);
		send(8'h02, 1'b0);
		send(8'h80, 1'b0);
		mst.bus_stop();
		`CHK(cfg, 4'b0010)
		$display("test config_reset done");
		wrap_up();
	end
endmodule // testbench

// ### rtl/athc_pkg.sv
// Constants and types for the converter track/hold and bus control block.
// Assumes a single system clock domain; bus pins arrive unsynchronised.
// Function
// - Produce 10-bit result, return over bus
// - Conversion takes exactly ten bit decisions
// - Internal clock: track on address rise eight
// - Internal clock: hold on ninth falling edge
// - Internal clock: convert, holding serial clock low
// - External clock: track on read bit rise
// - External clock: hold on byte rise two
// - Acquisition window follows serial clock periods
// - Single-ended: selected input against ground
// - Differential: positive minus negative pair
// - Differential unipolar: negative gives code zero
// - Unipolar binary, bipolar two's complement
// - Single-ended always unipolar, polarity ignored
// - One bit per serial clock cycle
// - Data change during clock high: control
// - Lines released high when bus idle
// - Address low bit selects read or write
// - Written MSB set: setup, else configuration
// - Polarity bit: one bipolar, reset zero
package athc_pkg;

	// ==========================================================
	// Sizes and timing
	localparam int RES_W = 10;
	localparam int CONV_STEPS = 10;
	localparam int SYS_PERIOD_NS = 5;
	localparam int INT_CONV_PERIOD_NS = 40;
	localparam int INT_CONV_DIV =
		(INT_CONV_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int DIV_W = 8;
	localparam int STEP_W = 4;

	// ==========================================================
	// Bus framing
	localparam logic [6:0] DEV_ADDR_RST = 7'h36;
	localparam logic [3:0] ADDR_LAST_RISE = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] EXT_HOLD_CNT = 4'h1;
	localparam logic [5:0] RD_PAD = 6'h3F;

	// ==========================================================
	// Written byte fields and reset values
	localparam int BYTE_REG_BIT = 7;
	localparam int SETUP_CLK_BIT = 3;
	localparam int SETUP_POL_BIT = 2;
	localparam int SETUP_KEEP_BIT = 1;
	localparam int CFG_CS_BIT = 1;
	localparam int CFG_SGL_BIT = 0;
	localparam logic CLK_EXT_RST = 1'h0;
	localparam logic POL_RST = 1'h0;
	localparam logic SGL_RST = 1'h1;
	localparam logic CS_RST = 1'h0;
	localparam logic [RES_W-1:0] SIGN_FLIP = 10'h200;
	localparam logic [RES_W-1:0] BIP_OFFSET = 10'h200;

	typedef struct packed {
		logic clk_ext;
		logic bipolar;
		logic single_ended;
		logic chan_sel;
	} athc_cfg_type;

	localparam athc_cfg_type CFG_RST =
		'{CLK_EXT_RST, POL_RST, SGL_RST, CS_RST};

	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK,
		ST_CONV, ST_RD, ST_RD_ACK, ST_IGNORE
	} athc_state_type;

endpackage

// ### rtl/athc_sar.sv
// Successive-approximation stepper: one bit decision per tick.
// Assumes target is stable from start until busy falls.
`timescale 1ns/1ps
module athc_sar import athc_pkg::*; (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Control
	input wire logic start_i,
	input wire logic tick_i,
	input wire logic flip_i,
	input wire logic [RES_W-1:0] target_i,
	// Result
	output logic busy_o,
	output logic done_o,
	output logic [RES_W-1:0] code_o
);

	// ==========================================================
	// Bit decisions
	logic [RES_W-1:0] raw_r, raw_nxt, code_nxt, trial;
	logic [STEP_W-1:0] step_r, step_nxt;
	logic flip_r, flip_nxt, busy_nxt, done_nxt;

	always_comb begin
		raw_nxt = raw_r;
		step_nxt = step_r;
		flip_nxt = flip_r;
		busy_nxt = busy_o;
		done_nxt = done_o;
		trial = raw_r | (RES_W'(1) << step_r);
		if (start_i) begin
			raw_nxt = '0;
			step_nxt = STEP_W'(CONV_STEPS - 1);
			flip_nxt = flip_i;
			busy_nxt = 1'b1;
			done_nxt = 1'b0;
		end else if (busy_o && tick_i) begin
			if (target_i >= trial)
				raw_nxt = trial;
			step_nxt = step_r - STEP_W'(1);
			if (step_r == '0) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
		code_nxt = raw_nxt ^ (flip_nxt ? SIGN_FLIP : '0);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			raw_r <= '0;
			step_r <= '0;
			flip_r <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			code_o <= '0;
		end else begin
			raw_r <= raw_nxt;
			step_r <= step_nxt;
			flip_r <= flip_nxt;
			busy_o <= busy_nxt;
			done_o <= done_nxt;
			code_o <= code_nxt;
		end
	end

endmodule // athc_sar

// ### rtl/athc_top.sv
// Track/hold sequencing, bus slave and conversion control.
// Assumes open-drain bus lines resolved outside; master obeys bus timing.
`timescale 1ns/1ps
module athc_top import athc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_RST,
	parameter int CONV_DIV = INT_CONV_DIV
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Serial clock pin
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	// Serial data pin
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Sampled input levels
	input wire logic [RES_W-1:0] analog_input_zero_i,
	input wire logic [RES_W-1:0] analog_input_one_i,
	// Status
	output athc_cfg_type cfg_o,
	output logic track_o,
	output logic busy_o,
	output logic result_valid_o,
	output logic [RES_W-1:0] result_o
);

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [1:0] scl_s_r, sda_s_r;
	logic scl_d_r, sda_d_r, zero_r;
	logic [RES_W-1:0] a0_m_r, a0_r, a1_m_r, a1_r;
	logic scl_rise, scl_fall, bus_start, bus_stop, sda;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			zero_r <= 1'b0;
			a0_m_r <= '0;
			a0_r <= '0;
			a1_m_r <= '0;
			a1_r <= '0;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_i};
			sda_s_r <= {sda_s_r[0], sda_i};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
			zero_r <= 1'b0;
			a0_m_r <= analog_input_zero_i;
			a0_r <= a0_m_r;
			a1_m_r <= analog_input_one_i;
			a1_r <= a1_m_r;
		end
	end

	assign sda = sda_s_r[1];
	assign scl_rise = scl_s_r[1] & ~scl_d_r;
	assign scl_fall = ~scl_s_r[1] & scl_d_r;
	assign bus_start = scl_s_r[1] & scl_d_r & sda_d_r & ~sda;
	assign bus_stop = scl_s_r[1] & scl_d_r & ~sda_d_r & sda;

	// ==========================================================
	// Input selection and output coding
	function automatic logic [RES_W-1:0] pick_code(
		athc_cfg_type c, logic [RES_W-1:0] a0, logic [RES_W-1:0] a1);
		logic [RES_W-1:0] p;
		logic [RES_W-1:0] n;
		logic signed [RES_W:0] d;
		logic signed [RES_W:0] h;
		p = c.chan_sel ? a1 : a0;
		n = c.chan_sel ? a0 : a1;
		d = $signed({1'b0, p}) - $signed({1'b0, n});
		h = (d >>> 1) + $signed({1'b0, BIP_OFFSET});
		if (c.single_ended)
			return p;
		else if (!c.bipolar)
			return d[RES_W] ? '0 : d[RES_W-1:0];
		else
			return h[RES_W-1:0];
	endfunction

	function automatic logic rd_bit(logic second, logic [3:0] idx,
		logic [RES_W-1:0] code);
		logic [7:0] b;
		b = second ? code[7:0] : {RD_PAD, code[RES_W-1:8]};
		return b[3'(4'h7 - idx)];
	endfunction

	// ==========================================================
	// Sequencer
	athc_state_type state_r, state_nxt;
	athc_cfg_type cfg_r, cfg_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [RES_W-1:0] target_r, target_nxt;
	logic rd_r, rd_nxt, byte_r, byte_nxt, track_r, track_nxt;
	logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
	logic start_r, start_nxt, sar_busy, sar_done, tick;
	logic [RES_W-1:0] sar_code;

	assign tick = sar_busy && !start_r &&
		(cfg_r.clk_ext ? scl_rise :
		(state_r == ST_CONV && div_r == DIV_W'(CONV_DIV - 1)));

	always_comb begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		div_nxt = div_r;
		target_nxt = target_r;
		rd_nxt = rd_r;
		byte_nxt = byte_r;
		track_nxt = track_r;
		sda_oe_nxt = sda_oe_r;
		scl_oe_nxt = scl_oe_r;
		start_nxt = 1'b0;
		if (bus_stop) begin
			state_nxt = ST_IDLE;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
			track_nxt = 1'b0;
		end else if (bus_start) begin
			state_nxt = ST_ADDR;
			cnt_nxt = '0;
			sda_oe_nxt = 1'b0;
		end else begin
			unique case (state_r)
			ST_IDLE, ST_IGNORE: begin
			end
			ST_ADDR, ST_WR: begin
				if (scl_rise) begin
					shift_nxt = {shift_r[6:0], sda};
					cnt_nxt = cnt_r + 4'h1;
					if (state_r == ST_ADDR && cnt_r == ADDR_LAST_RISE &&
						shift_r[6:0] == DEV_ADDR && sda)
						track_nxt = 1'b1;
				end
				if (scl_fall && cnt_r == BYTE_BITS) begin
					if (state_r == ST_WR) begin
						sda_oe_nxt = 1'b1;
						state_nxt = ST_WR_ACK;
						if (shift_r[BYTE_REG_BIT]) begin
							cfg_nxt.clk_ext = shift_r[SETUP_CLK_BIT];
							cfg_nxt.bipolar = shift_r[SETUP_POL_BIT];
						end else begin
							cfg_nxt.single_ended = shift_r[CFG_SGL_BIT];
							cfg_nxt.chan_sel = shift_r[CFG_CS_BIT];
						end
						if (shift_r[BYTE_REG_BIT] && !shift_r[SETUP_KEEP_BIT]) begin
							cfg_nxt.single_ended = SGL_RST;
							cfg_nxt.chan_sel = CS_RST;
						end
					end else if (shift_r[7:1] == DEV_ADDR) begin
						sda_oe_nxt = 1'b1;
						rd_nxt = shift_r[0];
						state_nxt = ST_ADDR_ACK;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
			end
			ST_WR_ACK: begin
				if (scl_fall) begin
					sda_oe_nxt = 1'b0;
					cnt_nxt = '0;
					state_nxt = ST_WR;
				end
			end
			ST_ADDR_ACK: begin
				if (scl_fall) begin
					cnt_nxt = '0;
					byte_nxt = 1'b0;
					sda_oe_nxt = 1'b0;
					if (!rd_r) begin
						state_nxt = ST_WR;
					end else if (cfg_r.clk_ext) begin
						sda_oe_nxt = ~rd_bit(1'b0, 4'h0, sar_code);
						state_nxt = ST_RD;
					end else begin
						track_nxt = 1'b0;
						target_nxt = pick_code(cfg_r, a0_r, a1_r);
						start_nxt = 1'b1;
						scl_oe_nxt = 1'b1;
						div_nxt = '0;
						state_nxt = ST_CONV;
					end
				end
			end
			ST_CONV: begin
				div_nxt = (div_r == DIV_W'(CONV_DIV - 1)) ? '0 :
					div_r + DIV_W'(1);
				if (!start_r && !sar_busy) begin
					scl_oe_nxt = 1'b0;
					sda_oe_nxt = ~rd_bit(1'b0, 4'h0, sar_code);
					state_nxt = ST_RD;
				end
			end
			ST_RD: begin
				if (scl_rise) begin
					cnt_nxt = cnt_r + 4'h1;
					if (cfg_r.clk_ext && !byte_r && cnt_r == EXT_HOLD_CNT) begin
						track_nxt = 1'b0;
						target_nxt = pick_code(cfg_r, a0_r, a1_r);
						start_nxt = 1'b1;
					end
				end
				if (scl_fall) begin
					if (cnt_r == BYTE_BITS) begin
						sda_oe_nxt = 1'b0;
						state_nxt = ST_RD_ACK;
					end else begin
						sda_oe_nxt = ~rd_bit(byte_r, cnt_r, sar_code);
					end
				end
			end
			ST_RD_ACK: begin
				if (scl_rise) begin
					shift_nxt[0] = sda;
					if (cfg_r.clk_ext && byte_r && !sda)
						track_nxt = 1'b1;
				end
				if (scl_fall) begin
					if (!shift_r[0]) begin
						byte_nxt = ~byte_r;
						cnt_nxt = '0;
						sda_oe_nxt = ~rd_bit(~byte_r, 4'h0, sar_code);
						state_nxt = ST_RD;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= ST_IDLE;
			cfg_r <= CFG_RST;
			cnt_r <= '0;
			shift_r <= '0;
			div_r <= '0;
			target_r <= '0;
			rd_r <= 1'b0;
			byte_r <= 1'b0;
			track_r <= 1'b0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			div_r <= div_nxt;
			target_r <= target_nxt;
			rd_r <= rd_nxt;
			byte_r <= byte_nxt;
			track_r <= track_nxt;
			sda_oe_r <= sda_oe_nxt;
			scl_oe_r <= scl_oe_nxt;
			start_r <= start_nxt;
		end
	end

	// ==========================================================
	// Converter
	athc_sar u_sar (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.start_i(start_r),
		.tick_i(tick),
		.flip_i(cfg_r.bipolar && !cfg_r.single_ended),
		.target_i(target_r),
		.busy_o(sar_busy),
		.done_o(sar_done),
		.code_o(sar_code)
	);

	assign scl_o = zero_r;
	assign sda_o = zero_r;
	assign scl_oe_o = scl_oe_r;
	assign sda_oe_o = sda_oe_r;
	assign cfg_o = cfg_r;
	assign track_o = track_r;
	assign busy_o = sar_busy;
	assign result_valid_o = sar_done;
	assign result_o = sar_code;

	// ==========================================================
	// Checks
	logic [STEP_W-1:0] ticks_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			ticks_r <= '0;
		else if (start_r)
			ticks_r <= '0;
		else if (tick && sar_busy)
			ticks_r <= ticks_r + STEP_W'(1);
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_ten_steps;
		$fell(sar_busy) |-> ticks_r == STEP_W'(CONV_STEPS);
	endproperty
	a_ten_steps: assert property (p_ten_steps) else $error("step count");

	property p_track;
		state_r == ST_ADDR && scl_rise && cnt_r == ADDR_LAST_RISE &&
		shift_r[6:0] == DEV_ADDR && sda && !bus_stop && !bus_start
		|=> track_r;
	endproperty
	a_track: assert property (p_track) else $error("no track");

	property p_int_hold;
		state_r == ST_ADDR_ACK && scl_fall && rd_r && !cfg_r.clk_ext &&
		!bus_stop && !bus_start |=> !track_r && scl_oe_r ##1 sar_busy;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("int hold");

	property p_scl_low;
		state_r == ST_CONV |-> scl_oe_r;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl free");

	property p_ext_hold;
		state_r == ST_RD && scl_rise && cfg_r.clk_ext && !byte_r &&
		cnt_r == EXT_HOLD_CNT && !bus_stop && !bus_start
		|=> !track_r && start_r ##1 sar_busy;
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("ext hold");

	property p_uni_code;
		$rose(sar_done) && !cfg_r.bipolar |-> result_o == target_r;
	endproperty
	a_uni_code: assert property (p_uni_code) else $error("uni code");

	property p_bip_code;
		$rose(sar_done) && cfg_r.bipolar && !cfg_r.single_ended
		|-> result_o == (target_r ^ SIGN_FLIP);
	endproperty
	a_bip_code: assert property (p_bip_code) else $error("bip code");

	property p_release;
		bus_stop |=> (!sda_oe_r && !scl_oe_r) [*2];
	endproperty
	a_release: assert property (p_release) else $error("not freed");

	property p_setup;
		state_r == ST_WR && scl_fall && cnt_r == BYTE_BITS &&
		shift_r[BYTE_REG_BIT] && !bus_stop && !bus_start
		|=> cfg_r.bipolar == $past(shift_r[SETUP_POL_BIT]);
	endproperty
	a_setup: assert property (p_setup) else $error("setup lost");

	c_int_conv: cover property ($fell(sar_busy) && !cfg_r.clk_ext);
	c_ext_conv: cover property ($fell(sar_busy) && cfg_r.clk_ext);
	c_setup_wr: cover property (state_r == ST_WR_ACK && shift_r[7]);
	c_second: cover property (state_r == ST_RD && byte_r);

endmodule // athc_top
